// ==== include/refclk_pkg.sv ====
// constants and types shared by the reference output selection logic
package refclk_pkg;

	// register byte addresses on the avalon slave
	localparam logic [3:0] ADDR_CFG    = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;

	// reference_output_config field positions
	localparam int BIT_JA_BYPASS  = 6;
	localparam int BIT_HOLD       = 5;
	localparam int BIT_SYN_BYPASS = 4;
	localparam int BIT_FREE       = 3;
	localparam int FREQ_LSB       = 0;
	localparam int FREQ_W         = 3;
	localparam int CFG_W          = 7;

	// reset value of the writable config bits (bit 7 is not stored)
	localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;

	// frequency-select codes with special meaning
	localparam logic [FREQ_W-1:0] FREQ_PASS     = 3'h0;
	localparam logic [FREQ_W-1:0] FREQ_RESERVED = 3'h3;

	// status register field positions
	localparam int ST_MODE_A_LSB = 0;
	localparam int ST_MODE_B_LSB = 8;
	localparam int ST_UNDEF      = 16;
	localparam int ST_LOST_A     = 17;
	localparam int ST_LOST_B     = 18;
	localparam int ST_E1_A       = 19;
	localparam int ST_E1_B       = 20;

	// what a reference output carries
	typedef enum logic [4:0] {
		MODE_SOURCE      = 5'b00001,
		MODE_SYNTH_LOCK  = 5'b00010,
		MODE_SYNTH_FREE  = 5'b00100,
		MODE_LINE_FREE   = 5'b01000,
		MODE_HIGH        = 5'b10000
	} out_mode_e;

endpackage

// ==== rtl/ref_output_stage.sv ====
// output stage of one reference clock pin: registered mode, clock mux
`timescale 1ns/1ps
module ref_output_stage
	import refclk_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire refclk_pkg::out_mode_e mode_d,
	input  wire logic                 source_clk,
	input  wire logic                 synth_clk,
	input  wire logic                 line_free_clk,
	output      refclk_pkg::out_mode_e mode,
	output      logic                 ref_out
);
	import refclk_pkg::*;

	typedef struct packed {
		out_mode_e mode;
	} stage_s;

	stage_s s_q;
	stage_s s_d;

	always_comb begin
		s_d      = s_q;
		s_d.mode = mode_d;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_q.mode <= MODE_HIGH;
		end else begin
			s_q <= s_d;
		end
	end

	assign mode = s_q.mode;

	// select changes only on sys_clk edges or at the asynchronous reset; a short glitch on a change is accepted
	always_comb begin
		case (s_q.mode)
			MODE_SOURCE:     ref_out = source_clk;
			MODE_SYNTH_LOCK: ref_out = synth_clk;
			MODE_SYNTH_FREE: ref_out = synth_clk;
			MODE_LINE_FREE:  ref_out = line_free_clk;
			default:         ref_out = 1'b1;
		endcase
	end

endmodule

// ==== rtl/reference_clock_output_select.sv ====
// reference output configuration register and source/mode selection
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// How it works
// - jitter bypass only affects recovered channel sources
// - bypass 0 uses attenuator, 1 uses recovery
// - hold setting matters only while source lost
// - output b lost, hold 0: T1/E1 free-run
// - output a ignores hold for external source
// - free-run bit only matters through synthesizer
// - free 0: synthesizer locked to source
// - free 1: synthesizer free-runs from master clock
// - external source lost: high or free-run
// - channel lost via synthesizer, free 0: hold picks high
// - channel lost, bypassed: T1/E1 free-run or high
// - frequency select honoured only when synthesizer enabled
// - locked frequency codes, 000 passes source frequency
// - free-run codes 000 and 011 undefined
module reference_clock_output_select
	import refclk_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output      logic [31:0]          avs_readdata,
	output      logic                 avs_waitrequest,
	input  wire logic                 src_a_is_channel,
	input  wire logic                 src_b_is_channel,
	input  wire logic                 src_a_lost,
	input  wire logic                 src_b_lost,
	input  wire logic                 src_a_is_e1,
	input  wire logic                 src_b_is_e1,
	input  wire logic                 rja_clk_a,
	input  wire logic                 cdr_clk_a,
	input  wire logic                 rja_clk_b,
	input  wire logic                 cdr_clk_b,
	input  wire logic                 external_ref_input,
	input  wire logic                 synth_out_clk,
	input  wire logic                 t1_free_clk,
	input  wire logic                 e1_free_clk,
	output      logic                 synth_ref_clk,
	output      logic                 synth_enable,
	output      logic                 synth_free_run,
	output      logic [2:0]           synth_freq_select,
	output      logic                 recovered_from_cdr_a,
	output      logic                 recovered_from_cdr_b,
	output      logic                 cfg_undefined,
	output      logic                 ref_out_a,
	output      logic                 ref_out_b
);
	import refclk_pkg::*;

	typedef struct packed {
		logic [CFG_W-1:0] cfg;
		logic             ack;
		logic [31:0]      rdata;
		logic             e1_a;
		logic             e1_b;
		logic             undef;
		logic [2:0]       freq;
		logic             syn_en;
		logic             free_run;
		logic             cdr_a;
		logic             cdr_b;
	} state_s;

	state_s    s_q;
	state_s    s_d;
	out_mode_e mode_a_d;
	out_mode_e mode_b_d;
	out_mode_e mode_a;
	out_mode_e mode_b;
	logic      jab;
	logic      hold;
	logic      syn_byp;
	logic      free;
	logic      src_clk_a;
	logic      src_clk_b;
	logic      line_clk_a;
	logic      line_clk_b;

	assign jab     = s_q.cfg[BIT_JA_BYPASS];
	assign hold    = s_q.cfg[BIT_HOLD];
	assign syn_byp = s_q.cfg[BIT_SYN_BYPASS];
	assign free    = s_q.cfg[BIT_FREE];

	// mode of output a from source kind, loss and the config bits
	function automatic out_mode_e pick_mode_a(input logic chan, input logic lost,
			input logic byp, input logic fr, input logic hd);
		if (!lost) begin
			if (byp) begin
				pick_mode_a = MODE_SOURCE;
			end else if (fr) begin
				pick_mode_a = MODE_SYNTH_FREE;
			end else begin
				pick_mode_a = MODE_SYNTH_LOCK;
			end
		end else if (!chan) begin
			// hold ignored for the external input
			pick_mode_a = (!byp && fr) ? MODE_SYNTH_FREE : MODE_HIGH;
		end else if (byp) begin
			pick_mode_a = hd ? MODE_HIGH : MODE_LINE_FREE;
		end else if (fr) begin
			pick_mode_a = MODE_SYNTH_FREE;
		end else begin
			pick_mode_a = hd ? MODE_HIGH : MODE_SYNTH_FREE;
		end
	endfunction

	// recovered clock path: attenuator or straight from recovery
	function automatic logic pick_src(input logic chan, input logic byp_ja,
			input logic rx_jitter_attenuator, input logic cdr, input logic ext);
		if (chan) begin
			pick_src = byp_ja ? cdr : rx_jitter_attenuator;
		end else begin
			pick_src = ext;
		end
	endfunction

	// combinations with no defined synthesizer output
	function automatic logic freq_undefined(input logic fr, input logic [2:0] code);
		if (fr) begin
			freq_undefined = (code == FREQ_PASS) || (code == FREQ_RESERVED);
		end else begin
			freq_undefined = (code == FREQ_RESERVED);
		end
	endfunction

	always_comb begin
		// output b has no synthesizer; hold applies only on loss
		if (!src_b_lost) begin
			mode_b_d = MODE_SOURCE;
		end else begin
			mode_b_d = hold ? MODE_HIGH : MODE_LINE_FREE;
		end
		mode_a_d = pick_mode_a(src_a_is_channel, src_a_lost, syn_byp, free, hold);
	end

	assign src_clk_a  = pick_src(src_a_is_channel, jab, rja_clk_a, cdr_clk_a, external_ref_input);
	assign src_clk_b  = pick_src(src_b_is_channel, jab, rja_clk_b, cdr_clk_b, external_ref_input);
	// standard remembered from before the loss picks 1.544 or 2.048 MHz
	assign line_clk_a = s_q.e1_a ? e1_free_clk : t1_free_clk;
	assign line_clk_b = s_q.e1_b ? e1_free_clk : t1_free_clk;
	assign synth_ref_clk = src_clk_a;

	always_comb begin
		s_d     = s_q;
		s_d.ack = (avs_read || avs_write) && !s_q.ack;
		if (!src_a_lost) begin
			s_d.e1_a = src_a_is_e1;
		end
		if (!src_b_lost) begin
			s_d.e1_b = src_b_is_e1;
		end
		// synthesizer controls held at rest while it is bypassed
		s_d.syn_en   = !syn_byp;
		s_d.free_run = !syn_byp && free;
		s_d.freq     = syn_byp ? FREQ_PASS : s_q.cfg[FREQ_LSB +: FREQ_W];
		s_d.undef    = !syn_byp && freq_undefined(free, s_q.cfg[FREQ_LSB +: FREQ_W]);
		s_d.cdr_a    = src_a_is_channel && jab;
		s_d.cdr_b    = src_b_is_channel && jab;
		// write lands on the edge where waitrequest is low
		if (s_q.ack && avs_write && avs_address == ADDR_CFG && avs_byteenable[0]) begin
			s_d.cfg = avs_writedata[CFG_W-1:0];
		end
		// read data loaded one edge ahead so it stands while waitrequest is low
		if (s_d.ack && avs_read) begin
			s_d.rdata = 32'h0000_0000;
			if (avs_address == ADDR_CFG) begin
				s_d.rdata[CFG_W-1:0] = s_q.cfg;
			end else if (avs_address == ADDR_STATUS) begin
				s_d.rdata[ST_MODE_A_LSB +: 5] = mode_a;
				s_d.rdata[ST_MODE_B_LSB +: 5] = mode_b;
				s_d.rdata[ST_UNDEF]           = s_q.undef;
				s_d.rdata[ST_LOST_A]          = src_a_lost;
				s_d.rdata[ST_LOST_B]          = src_b_lost;
				s_d.rdata[ST_E1_A]            = s_q.e1_a;
				s_d.rdata[ST_E1_B]            = s_q.e1_b;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_q.cfg      <= CFG_RESET;
			s_q.ack      <= 1'b0;
			s_q.rdata    <= 32'h0000_0000;
			s_q.e1_a     <= 1'b0;
			s_q.e1_b     <= 1'b0;
			s_q.undef    <= 1'b0;
			s_q.freq     <= FREQ_PASS;
			s_q.syn_en   <= 1'b0;
			s_q.free_run <= 1'b0;
			s_q.cdr_a    <= 1'b0;
			s_q.cdr_b    <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_waitrequest      = (avs_read || avs_write) && !s_q.ack;
	assign avs_readdata         = s_q.rdata;
	assign synth_enable         = s_q.syn_en;
	assign synth_free_run       = s_q.free_run;
	assign synth_freq_select    = s_q.freq;
	assign recovered_from_cdr_a = s_q.cdr_a;
	assign recovered_from_cdr_b = s_q.cdr_b;
	assign cfg_undefined        = s_q.undef;

	ref_output_stage stage_a (
		.sys_clk       (sys_clk),
		.rst           (rst),
		.mode_d        (mode_a_d),
		.source_clk    (src_clk_a),
		.synth_clk     (synth_out_clk),
		.line_free_clk (line_clk_a),
		.mode          (mode_a),
		.ref_out       (ref_out_a)
	);

	// output b bypasses the synthesizer, its synth input is unused
	ref_output_stage stage_b (
		.sys_clk       (sys_clk),
		.rst           (rst),
		.mode_d        (mode_b_d),
		.source_clk    (src_clk_b),
		.synth_clk     (1'b1),
		.line_free_clk (line_clk_b),
		.mode          (mode_b),
		.ref_out       (ref_out_b)
	);

endmodule

// ==== sim/refclk_partner.sv ====
// far-side model: free-running source, synthesizer and line clocks
`timescale 1ns/1ps
module refclk_partner (
	output logic [7:0] clks
);
	for (genvar i = 0; i < 8; i++) begin : g_clk
		logic c;
		// odd phases keep every edge clear of the bench sampling instants
		initial begin
			c = 1'b0;
			#(0.37 + i);
			forever #(7.3 + 2.0 * i) c = ~c;
		end
		assign clks[i] = c;
	end
endmodule

// ==== sim/refclk_props.sv ====
// assertion checker for the reference output selection block
`timescale 1ns/1ps
module refclk_props (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        src_a_is_channel,
	input wire logic        src_b_is_channel,
	input wire logic        synth_enable,
	input wire logic        synth_free_run,
	input wire logic [2:0]  synth_freq_select,
	input wire logic        recovered_from_cdr_a,
	input wire logic        recovered_from_cdr_b,
	input wire logic        cfg_undefined
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held beyond one cycle");
	AST_BIT7_ZERO: assert property (avs_read && !avs_waitrequest |-> !avs_readdata[7])
		else $error("reserved bit read as one");
	AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address != 4'h0
		&& avs_address != 4'h4 |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_FREE_SYNTH: assert property (synth_free_run |-> synth_enable)
		else $error("free run without synthesizer");
	AST_FREQ_GATED: assert property (!synth_enable |-> synth_freq_select == 3'h0)
		else $error("frequency select passed while bypassed");
	AST_UNDEF_SYNTH: assert property (cfg_undefined |-> synth_enable)
		else $error("undefined flag while bypassed");
	AST_CDR_A: assert property (recovered_from_cdr_a |-> $past(src_a_is_channel))
		else $error("recovery path on external source a");
	AST_CDR_B: assert property (recovered_from_cdr_b |-> $past(src_b_is_channel))
		else $error("recovery path on external source b");
endmodule
bind reference_clock_output_select refclk_props CHK (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.src_a_is_channel(src_a_is_channel), .src_b_is_channel(src_b_is_channel),
	.synth_enable(synth_enable), .synth_free_run(synth_free_run),
	.synth_freq_select(synth_freq_select), .recovered_from_cdr_a(recovered_from_cdr_a),
	.recovered_from_cdr_b(recovered_from_cdr_b), .cfg_undefined(cfg_undefined)
);

// ==== sim/tb.sv ====
// self-checking bench for the reference output selection block
`timescale 1ns/1ps
module tb;
	import refclk_pkg::*;
	logic        sys_clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
	logic        ch = 1'b0, la = 1'b0, lb = 1'b0, e1 = 1'b0;
	logic [3:0]  addr = 4'h0, be = 4'hf;
	logic [31:0] wdata = 32'h0000_0000, rdata, q;
	logic        wreq, syn_en, syn_fr, undef, cdr_a, cdr_b, out_a, out_b;
	logic [2:0]  syn_fs;
	logic [7:0]  clks, c;
	int          miscompares = 0, comparisons = 0, cyc = 0;
	refclk_partner PEER (.clks(clks));
	reference_clock_output_select DUT (
		.sys_clk(sys_clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .src_a_is_channel(ch), .src_b_is_channel(ch),
		.src_a_lost(la), .src_b_lost(lb), .src_a_is_e1(e1), .src_b_is_e1(e1),
		.rja_clk_a(clks[0]), .cdr_clk_a(clks[1]), .rja_clk_b(clks[2]), .cdr_clk_b(clks[3]),
		.external_ref_input(clks[4]), .synth_out_clk(clks[5]), .t1_free_clk(clks[6]),
		.e1_free_clk(clks[7]), .synth_ref_clk(), .synth_enable(syn_en),
		.synth_free_run(syn_fr), .synth_freq_select(syn_fs), .recovered_from_cdr_a(cdr_a),
		.recovered_from_cdr_b(cdr_b), .cfg_undefined(undef), .ref_out_a(out_a),
		.ref_out_b(out_b)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one request, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] b, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= b;
		// sampled at the rising edge, before that edge's updates land
		do begin
			@(posedge sys_clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (n >= 20)
			check("waitrequest", wreq, 1'b0);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// standard captured first while present, then the loss applied
	task automatic mode(input logic [7:0] cf, input logic h, l_a, l_b, ee,
			input logic [4:0] ea, eb);
		ch <= h;
		e1 <= ee;
		la <= 1'b0;
		lb <= 1'b0;
		bus(1'b1, ADDR_CFG, {24'h00_0000, cf}, 4'h1, q);
		@(posedge sys_clk);
		la <= l_a;
		lb <= l_b;
		repeat (3) @(posedge sys_clk);
		bus(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hf, q);
		#1;
		check("mode_a", q[4:0], ea);
		check("mode_b", q[12:8], eb);
		check("cdr_a", cdr_a, h & cf[6]);
		if (ea == MODE_HIGH)
			check("out_a", out_a, 1'b1);
		if (eb == MODE_LINE_FREE)
			check("out_b", out_b, ee ? clks[7] : clks[6]);
	endtask
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		// whole run needs well under a thousand cycles
		if (cyc == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		check("out_a", out_a, 1'b1);
		check("out_b", out_b, 1'b1);
		rst <= 1'b0;
		bus(1'b0, ADDR_CFG, 32'h0000_0000, 4'hf, q);
		check("cfg", q, 32'h0000_0000);
		bus(1'b1, ADDR_CFG, 32'h0000_00ff, 4'hf, q);
		bus(1'b0, ADDR_CFG, 32'h0000_0000, 4'hf, q);
		check("cfg", q, 32'h0000_007f);
		bus(1'b1, ADDR_CFG, 32'h0000_0000, 4'he, q);
		bus(1'b0, ADDR_CFG, 32'h0000_0000, 4'hf, q);
		check("cfg", q, 32'h0000_007f);
		bus(1'b0, 4'h8, 32'h0000_0000, 4'hf, q);
		check("unmapped", q, 32'h0000_0000);
		$display("register test done");
		for (int i = 0; i < 24; i++) begin
			c = {3'b000, i >= 16, i / 8 == 1, i[2:0]};
			bus(1'b1, ADDR_CFG, {24'h00_0000, c}, 4'hf, q);
			bus(1'b0, ADDR_CFG, 32'h0000_0000, 4'hf, q);
			#1;
			check("cfg", q, {24'h00_0000, c});
			check("syn_en", syn_en, !c[4]);
			check("syn_fs", syn_fs, c[4] ? 3'h0 : c[2:0]);
			check("syn_fr", syn_fr, !c[4] && c[3]);
			check("undef", undef, !c[4] && (c[2:0] == FREQ_RESERVED
				|| c[3] && c[2:0] == FREQ_PASS));
			check("out_a", out_a, c[4] ? clks[4] : clks[5]);
		end
		$display("synthesizer test done");
		mode(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, MODE_SYNTH_LOCK, MODE_SOURCE);
		mode(8'h28, 1'b0, 1'b0, 1'b0, 1'b0, MODE_SYNTH_FREE, MODE_SOURCE);
		mode(8'h10, 1'b1, 1'b0, 1'b0, 1'b0, MODE_SOURCE, MODE_SOURCE);
		mode(8'h00, 1'b0, 1'b1, 1'b1, 1'b1, MODE_HIGH, MODE_LINE_FREE);
		mode(8'h10, 1'b0, 1'b1, 1'b1, 1'b0, MODE_HIGH, MODE_LINE_FREE);
		mode(8'h08, 1'b0, 1'b1, 1'b0, 1'b0, MODE_SYNTH_FREE, MODE_SOURCE);
		mode(8'h30, 1'b0, 1'b1, 1'b1, 1'b0, MODE_HIGH, MODE_HIGH);
		mode(8'h00, 1'b1, 1'b1, 1'b0, 1'b0, MODE_SYNTH_FREE, MODE_SOURCE);
		mode(8'h20, 1'b1, 1'b1, 1'b0, 1'b0, MODE_HIGH, MODE_SOURCE);
		mode(8'h50, 1'b1, 1'b1, 1'b0, 1'b1, MODE_LINE_FREE, MODE_SOURCE);
		mode(8'h70, 1'b1, 1'b1, 1'b0, 1'b0, MODE_HIGH, MODE_SOURCE);
		mode(8'h40, 1'b0, 1'b0, 1'b0, 1'b0, MODE_SYNTH_LOCK, MODE_SOURCE);
		$display("mode test done");
		end_of_test();
	end
endmodule
